// ==== bvs_regs.vh ====
// register map, field layout and voltage decode constants for buck select
// Contract
// RULE1 - top bit chooses external adjust; when low the 6-bit code sets output
// RULE2 - each control register is 8 bits, all read/write, bit 6 unused
// RULE3 - second regulator control register lives at address 0x0f, protected
// RULE4 - codes 0 to 23 decode from 0.900 V upward in 25 mV steps
// RULE5 - codes 24-52 step 50 mV, 53-56 step 100 mV, above 56 hold 3.300 V
// RULE6 - protected writes without a valid unlock are ignored by the device
`ifndef BVS_REGS_VH
`define BVS_REGS_VH

// register addresses
`define BVS_ADDR_ONE 8'h0e
`define BVS_ADDR_TWO 8'h0f

// field layout
`define BVS_EXT_BIT 7
`define BVS_SPARE_BIT 6
`define BVS_CODE_MSB 5
`define BVS_CODE_LSB 0

// decode breakpoints, in code units
`define BVS_SEG2_CODE 6'h18
`define BVS_SEG3_CODE 6'h35
`define BVS_SAT_CODE 6'h38

// decode base values and steps, in millivolts
`define BVS_SEG1_BASE_MV 12'h384
`define BVS_SEG1_STEP_MV 12'h019
`define BVS_SEG2_BASE_MV 12'h5dc
`define BVS_SEG2_STEP_MV 12'h032
`define BVS_SEG3_BASE_MV 12'hbb8
`define BVS_SEG3_STEP_MV 12'h064
`define BVS_SAT_MV 12'hce4

// neutral values for read data and cleared state
`define BVS_ZERO_BYTE 8'h00
`define BVS_ZERO_MV 12'h000

`endif

// ==== bvs_vdecode.v ====
// voltage code to millivolt decoder for one buck regulator
`timescale 1ns/1ps
`include "bvs_regs.vh"

module bvs_vdecode (
  code,
  target_mv
);
  input wire [5:0] code;
  output reg [11:0] target_mv;

  reg [11:0] code_w;

  // piecewise table; three linear segments then a flat top
  always @* begin
    code_w = {6'h00, code};
    if (code < `BVS_SEG2_CODE) begin
      target_mv = `BVS_SEG1_BASE_MV + code_w * `BVS_SEG1_STEP_MV; // RULE4
    end else if (code < `BVS_SEG3_CODE) begin
      target_mv = `BVS_SEG2_BASE_MV +
        (code_w - {6'h00, `BVS_SEG2_CODE}) * `BVS_SEG2_STEP_MV; // RULE5
    end else if (code < `BVS_SAT_CODE) begin
      target_mv = `BVS_SEG3_BASE_MV +
        (code_w - {6'h00, `BVS_SEG3_CODE}) * `BVS_SEG3_STEP_MV; // RULE5
    end else begin
      target_mv = `BVS_SAT_MV; // RULE5
    end
  end

endmodule // bvs_vdecode

// ==== bvs_top.v ====
// buck regulator voltage select registers with protected write path
`timescale 1ns/1ps
`include "bvs_regs.vh"

module bvs_top #(
  parameter [7:0] RESET_ONE = 8'h00,
  parameter [7:0] RESET_TWO = 8'h00
) (
  mclk,
  rstn,
  reg_wr,
  reg_rd,
  reg_addr,
  reg_wdata,
  unlock_valid,
  reg_rdata,
  reg_rvalid,
  wr_ignored,
  buck_one_control,
  buck_two_control,
  buck_one_external_adjust_sel,
  buck_two_external_adjust_sel,
  buck_one_voltage_code,
  buck_two_voltage_code,
  buck_one_target_mv,
  buck_two_target_mv
);
  input wire mclk;
  input wire rstn;
  input wire reg_wr;
  input wire reg_rd;
  input wire [7:0] reg_addr;
  input wire [7:0] reg_wdata;
  input wire unlock_valid;
  output reg [7:0] reg_rdata;
  output reg reg_rvalid;
  output reg wr_ignored;
  output wire [7:0] buck_one_control;
  output wire [7:0] buck_two_control;
  output wire buck_one_external_adjust_sel;
  output wire buck_two_external_adjust_sel;
  output wire [5:0] buck_one_voltage_code;
  output wire [5:0] buck_two_voltage_code;
  output wire [11:0] buck_one_target_mv;
  output wire [11:0] buck_two_target_mv;

  reg [7:0] ctrl_r [0:1];
  reg [11:0] mv_r [0:1];
  wire [11:0] dec_mv [0:1];
  wire hit_one;
  wire hit_two;
  wire hit_any;

  // address decode; both control registers are protected locations
  assign hit_one = (reg_addr == `BVS_ADDR_ONE);
  assign hit_two = (reg_addr == `BVS_ADDR_TWO); // RULE3
  assign hit_any = hit_one | hit_two;

  // per regulator storage, decode and target hold
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : reg_ch
      wire sel;
      assign sel = (g == 0) ? hit_one : hit_two;

      // full byte stored; spare bit 6 kept, seen only on the control outputs and read data
      always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          ctrl_r[g] <= (g == 0) ? RESET_ONE : RESET_TWO;
        end else if (reg_wr && sel && unlock_valid) begin
          ctrl_r[g] <= reg_wdata; // RULE2 RULE6
        end
      end

      bvs_vdecode u_dec (
        .code(ctrl_r[g][`BVS_CODE_MSB:`BVS_CODE_LSB]),
        .target_mv(dec_mv[g])
      );

      // external adjust freezes no state but the code no longer regulates,
      // so the target reads zero to show the pin owns the output
      always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          mv_r[g] <= `BVS_ZERO_MV;
        end else if (ctrl_r[g][`BVS_EXT_BIT]) begin
          mv_r[g] <= `BVS_ZERO_MV; // RULE1
        end else begin
          mv_r[g] <= dec_mv[g]; // RULE1
        end
      end
    end
  endgenerate

  // read path is registered, one cycle after the strobe; unmapped reads zero
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= `BVS_ZERO_BYTE;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd && hit_one) begin
        reg_rdata <= ctrl_r[0]; // RULE2
      end else if (reg_rd && hit_two) begin
        reg_rdata <= ctrl_r[1]; // RULE2
      end else if (reg_rd) begin
        reg_rdata <= `BVS_ZERO_BYTE;
      end
    end
  end

  // one-cycle flag when a protected write is dropped for lack of unlock
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wr_ignored <= 1'b0;
    end else begin
      wr_ignored <= reg_wr & hit_any & ~unlock_valid; // RULE6
    end
  end

  assign buck_one_control = ctrl_r[0];
  assign buck_two_control = ctrl_r[1];
  assign buck_one_external_adjust_sel = ctrl_r[0][`BVS_EXT_BIT]; // RULE1
  assign buck_two_external_adjust_sel = ctrl_r[1][`BVS_EXT_BIT]; // RULE1
  assign buck_one_voltage_code = ctrl_r[0][`BVS_CODE_MSB:`BVS_CODE_LSB];
  assign buck_two_voltage_code = ctrl_r[1][`BVS_CODE_MSB:`BVS_CODE_LSB];
  assign buck_one_target_mv = mv_r[0];
  assign buck_two_target_mv = mv_r[1];

endmodule // bvs_top

// ==== bvs_properties.sv ====
// checker for the buck voltage select register bank
`timescale 1ns/1ps
module bvs_properties (
  input logic mclk, rstn, reg_wr, reg_rd, unlock_valid,
  input logic reg_rvalid, wr_ignored, buck_one_external_adjust_sel,
  input logic [7:0] reg_addr, reg_wdata, reg_rdata,
  input logic [7:0] buck_one_control, buck_two_control,
  input logic [5:0] buck_two_voltage_code,
  input logic [11:0] buck_one_target_mv, buck_two_target_mv
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  logic hit;
  // both control registers share one address pair, 0x0e and 0x0f
  assign hit = reg_addr[7:1] == 7'h07;
  a_read_valid: assert property (reg_rd |=> reg_rvalid)
    else $error("rvalid");
  a_unmapped_zero: assert property (reg_rd && !hit |=> !reg_rdata)
    else $error("rdata");
  a_refused_hold: assert property (reg_wr && hit && !unlock_valid
    |=> wr_ignored && $stable(buck_two_control)) else $error("ignore");
  a_write_two: assert property (reg_wr && hit && unlock_valid
    && reg_addr[0] |=> buck_two_control == $past(reg_wdata))
    else $error("write");
  a_ext_zero: assert property (buck_one_external_adjust_sel
    |=> buck_one_target_mv == 12'h000) else $error("ext");
  a_low_code: assert property (buck_one_control[7:6] == 2'h0
    && buck_one_control[5:0] == 6'h00 |=> buck_one_target_mv == 12'h384)
    else $error("low");
  a_sat_code: assert property (!buck_two_control[7]
    && buck_two_voltage_code > 6'h38 |=> buck_two_target_mv == 12'hce4)
    else $error("sat");
endmodule // bvs_properties
bind bvs_top bvs_properties u_bvs_properties (.*);

// ==== bvs_host.sv ====
// host model driving the register strobes of the select bank
`timescale 1ns/1ps
module bvs_host (
  input logic mclk,
  output logic reg_wr, reg_rd, unlock_valid,
  output logic [7:0] reg_addr, reg_wdata
);
  initial {reg_wr, reg_rd, unlock_valid, reg_addr, reg_wdata} = '0;
  // one strobe held over one rising edge; data inverted after release
  task acc(input logic w, input logic [7:0] a, d, input logic u);
    @(negedge mclk);
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
    unlock_valid = u;
    @(negedge mclk);
    {reg_wr, reg_rd} = 2'h0;
    reg_wdata = ~d;
  endtask
endmodule // bvs_host

// ==== testbench.sv ====
// self-checking bench for the buck voltage select register bank
`timescale 1ns/1ps
module testbench;
  logic mclk = 0, rstn = 0, reg_wr, reg_rd, unlock_valid;
  logic reg_rvalid, wr_ignored;
  logic buck_one_external_adjust_sel, buck_two_external_adjust_sel;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [7:0] buck_one_control, buck_two_control;
  logic [5:0] buck_one_voltage_code, buck_two_voltage_code;
  logic [11:0] buck_one_target_mv, buck_two_target_mv;
  int err_total = 0, comparisons = 0, m[2] = '{0, 0}, a, d, u;
  always #10 mclk = ~mclk;
  bvs_host u_bvs_host (.*);
  bvs_top u_bvs_top (.*);
  // reference decode, millivolts
  function int mv(int c, int x);
    if (x) return 0;
    if (c < 24) return 900 + 25 * c;
    if (c < 53) return 1500 + 50 * (c - 24);
    return c < 57 ? 3000 + 100 * (c - 53) : 3300;
  endfunction
  task chk(string n, logic [11:0] s, int e);
    comparisons++;
    if (s !== e[11:0]) begin
      err_total++;
      $display("Error %s expected %0d seen %0d", n, e, s);
    end
  endtask
  task close_out;
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // run takes about 21 us
  initial begin
    #50000;
    err_total++;
    close_out;
  end
  // random writes over 0x0d..0x10, every code, then read back
  initial begin
    u = $urandom(38598);
    repeat (8) @(negedge mclk);
    rstn = 1;
    @(negedge mclk);
    chk("r1", buck_one_target_mv, 900);
    chk("rc", buck_one_control, 0);
    for (int i = 0; i < 256; i++) begin
      a = 13 + $urandom % 4;
      d = ($urandom & 'hc0) | i % 64;
      u = $urandom % 2;
      u_bvs_host.acc(1, a[7:0], d[7:0], u[0]);
      chk("ign", wr_ignored, a inside {14, 15} && !u);
      if (u && a inside {14, 15}) m[a - 14] = d;
      u_bvs_host.acc(0, a[7:0], 8'h00, 1'b0);
      chk("rd", reg_rdata, a inside {14, 15} ? m[a - 14] : 0);
      chk("rv", reg_rvalid, 1);
      chk("t1", buck_one_target_mv, mv(m[0] % 64, m[0] / 128));
      chk("t2", buck_two_target_mv, mv(m[1] % 64, m[1] / 128));
      chk("x2", buck_two_external_adjust_sel, m[1] / 128);
      chk("c1", buck_one_voltage_code, m[0] % 64);
      chk("k2", buck_two_control, m[1]);
    end
    // mid-run reset must bring register two back to its reset byte and its target to 900 mV
    @(negedge mclk) rstn = 0;
    @(negedge mclk) rstn = 1;
    @(negedge mclk);
    chk("r2", buck_two_control, 0);
    chk("z2", buck_two_target_mv, 900);
    close_out;
  end
endmodule // testbench
